// file: core/overcurrent_filter_select.sv
/*
 * filter-select register for three step-down rails with the per-signal
 * deglitch filters it steers, a small interrupt block and a plain
 * register port. assumes detect inputs synchronous to clk and the
 * non-volatile defaults stable while nvm_load is requested.
 */
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [RQ1] bit 2 selects rail 3 long filter
// [RQ2] bit 1 selects rail 2 long filter
// [RQ3] bit 0 selects rail 1 long filter
// [RQ4] one select covers all three rail detects
// [RQ5] bits load from nonvolatile memory after reset
// [RQ6] fault only after unbroken full-length assertion
module overcurrent_filter_select
#(
   parameter int SHORT_CYC = ocf_pkg::SHORT_CYCLES,
   parameter int LONG_CYC  = ocf_pkg::LONG_CYCLES
)
(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output logic      [7:0] rdata,
   input  wire logic [2:0] nvm_defaults,
   input  wire logic [8:0] oc_raw,
   output logic      [8:0] oc_fault,
   output logic      [2:0] long_filter_sel,
   output logic            irq
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      LOAD_IDLE = 2'b00,
      LOAD_NVM  = 2'b01,
      LOAD_DONE = 2'b10
   } load_state_t;

   load_state_t               load_q;
   logic [2:0]                sel_q;
   logic [8:0]                status_q;
   logic [8:0]                mask_q;
   logic [8:0]                fault_prev_q;
   logic [7:0]                rdata_q;
   logic [8:0]                fault_w;
   logic [ocf_pkg::CNT_W-1:0] short_lim;
   logic [ocf_pkg::CNT_W-1:0] long_lim;

   assign short_lim = ocf_pkg::CNT_W'(SHORT_CYC);
   assign long_lim  = ocf_pkg::CNT_W'(LONG_CYC);

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction : hit

   wire wr_sel    = wr_en && hit(addr, ocf_pkg::FILTER_SEL_OFS);
   wire wr_status = wr_en && hit(addr, ocf_pkg::IRQ_STATUS_OFS);
   wire wr_mask   = wr_en && hit(addr, ocf_pkg::IRQ_MASK_OFS);
   wire wr_load   = wr_en && hit(addr, ocf_pkg::LOAD_CTRL_OFS)
                    && wdata[0];
   wire [8:0] rise = fault_w & ~fault_prev_q;
   wire [8:0] wclr = wr_status ? {1'b0, wdata} : 9'h000;

   // ---------------------------------------------------------------
   // nonvolatile default loader
   // ---------------------------------------------------------------
   // [RQ5] load after reset
   always_ff @(posedge clk)
   begin
      if (srst)
         load_q <= LOAD_IDLE;
      else
      begin
         case (load_q)
            LOAD_IDLE: load_q <= LOAD_NVM;
            LOAD_NVM:  load_q <= LOAD_DONE;
            LOAD_DONE: load_q <= wr_load ? LOAD_NVM : LOAD_DONE;
            default:   load_q <= LOAD_IDLE;
         endcase
      end
   end

   // [RQ5] nonvolatile then software
   always_ff @(posedge clk)
   begin
      if (srst)
         sel_q <= ocf_pkg::SEL_RESET;
      else if (load_q == LOAD_NVM)
         sel_q <= nvm_defaults;
      else if (wr_sel)
         sel_q <= wdata[2:0] & ocf_pkg::SEL_WRITE_MASK[2:0];
   end

   assign long_filter_sel = sel_q;

   // ---------------------------------------------------------------
   // filters: index r*3+k, k = high-side, low-side, low-side reverse
   // ---------------------------------------------------------------
   genvar r, k;
   generate
      for (r = 0; r < ocf_pkg::RAILS; r++)
      begin : g_rail
         // [RQ1] [RQ2] [RQ3] per-rail length
         wire [ocf_pkg::CNT_W-1:0] lim = sel_q[r] ? long_lim : short_lim;
         for (k = 0; k < ocf_pkg::SIGS_PER_RAIL; k++)
         begin : g_sig
            // [RQ4] shared rail length
            oc_filter oc_filter_i
            (
               .clk   (clk),
               .srst  (srst),
               .raw   (oc_raw[r*3+k]),
               .limit (lim),
               .fault (fault_w[r*3+k])
            );
         end
      end
   endgenerate

   assign oc_fault = fault_w;

   // ---------------------------------------------------------------
   // interrupts: set wins over clear
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         status_q     <= ocf_pkg::IRQ_RESET;
         mask_q       <= ocf_pkg::MASK_RESET;
         fault_prev_q <= 9'h000;
      end
      else
      begin
         status_q     <= (status_q & ~wclr) | rise;
         fault_prev_q <= fault_w;
         if (wr_mask)
            mask_q <= {1'b0, wdata};
      end
   end

   assign irq = |(status_q & ~mask_q);

   // ---------------------------------------------------------------
   // read port
   // ---------------------------------------------------------------
   wire [7:0] rd_mux =
      hit(addr, ocf_pkg::FILTER_SEL_OFS) ? {5'h00, sel_q} :
      hit(addr, ocf_pkg::IRQ_STATUS_OFS) ? status_q[7:0] :
      hit(addr, ocf_pkg::IRQ_MASK_OFS)   ? mask_q[7:0] :
      hit(addr, ocf_pkg::LOAD_CTRL_OFS)  ?
         {7'h00, status_q[8]} : 8'h00;

   always_ff @(posedge clk)
   begin
      if (srst)
         rdata_q <= 8'h00;
      else
         rdata_q <= rd_en ? rd_mux : 8'h00;
   end

   assign rdata = rdata_q;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_nvm;
      load_q == LOAD_NVM;
   endsequence

   property p_load;
      @(posedge clk) disable iff (srst)
      s_nvm |=> (sel_q == $past(nvm_defaults));
   endproperty
   a_load: assert property (p_load) else $error("nvm load lost"); // [RQ5]

   property p_wr;
      @(posedge clk) disable iff (srst)
      (wr_sel && load_q != LOAD_NVM) |=> (sel_q == $past(wdata[2:0]));
   endproperty
   a_wr: assert property (p_wr) else $error("select write lost"); // [RQ5]

   property p_r3;
      @(posedge clk) disable iff (srst)
      sel_q[2] |-> (g_rail[2].lim == long_lim);
   endproperty
   a_r3: assert property (p_r3) else $error("rail 3 length"); // [RQ1]

   property p_r2;
      @(posedge clk) disable iff (srst)
      !sel_q[1] |-> (g_rail[1].lim == short_lim);
   endproperty
   a_r2: assert property (p_r2) else $error("rail 2 length"); // [RQ2]

   property p_r1;
      @(posedge clk) disable iff (srst)
      sel_q[0] |-> (g_rail[0].lim == long_lim);
   endproperty
   a_r1: assert property (p_r1) else $error("rail 1 length"); // [RQ3]

   property p_drop;
      @(posedge clk) disable iff (srst)
      !oc_raw[0] |=> !oc_fault[0];
   endproperty
   a_drop: assert property (p_drop) else $error("fault w/o raw"); // [RQ6]

   property p_rise;
      @(posedge clk) disable iff (srst)
      $rose(oc_fault[4]) |-> $past(oc_raw[4], 2);
   endproperty
   a_rise: assert property (p_rise) else $error("early fault"); // [RQ6]

   property p_irq;
      @(posedge clk) disable iff (srst)
      (rise != 9'h000) |=> (status_q & $past(rise)) == $past(rise);
   endproperty
   a_irq: assert property (p_irq) else $error("event lost"); // [RQ6]
endmodule : overcurrent_filter_select
`default_nettype wire

// file: shared/ocf_pkg.sv
/*
 * constants for the overcurrent filter-select block: register map,
 * field positions, reset values, filter timing.
 * assumes a single 100 MHz clock domain.
 */
package ocf_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] FILTER_SEL_OFS  = 8'h23;
   localparam logic [7:0] IRQ_STATUS_OFS  = 8'h40;
   localparam logic [7:0] IRQ_MASK_OFS    = 8'h41;
   localparam logic [7:0] LOAD_CTRL_OFS   = 8'h42;
   localparam int         RAILS           = 3;
   localparam int         SIGS_PER_RAIL   = 3;
   localparam int         DETECTS         = RAILS * SIGS_PER_RAIL;
   localparam logic [7:0] SEL_WRITE_MASK  = 8'h07;
   localparam logic [2:0] SEL_RESET       = 3'h0;
   localparam logic [8:0] IRQ_RESET       = 9'h000;
   localparam logic [8:0] MASK_RESET      = 9'h000;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ        = 100;
   localparam int SHORT_FILT_US  = 20;
   localparam int LONG_FILT_MS   = 2;
   localparam int SHORT_CYCLES   = SHORT_FILT_US * CLK_MHZ;
   localparam int LONG_CYCLES    = LONG_FILT_MS * 1000 * CLK_MHZ;
   localparam int CNT_W          = 18;
endpackage : ocf_pkg

// file: core/oc_filter.sv
/*
 * one deglitch filter for a single overcurrent detect signal.
 * assumes raw detect is already synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module oc_filter
(
   input  wire logic                       clk,
   input  wire logic                       srst,
   input  wire logic                       raw,
   input  wire logic [ocf_pkg::CNT_W-1:0]  limit,
   output logic                            fault
);
   logic [ocf_pkg::CNT_W-1:0] cnt_q;
   logic                      fault_q;
   wire                       reached = (cnt_q >= limit - 18'h00001);

   // count while raw stays high
   // [RQ6] drop restarts count
   always_ff @(posedge clk)
   begin
      if (srst || !raw)
      begin
         cnt_q   <= '0;
         fault_q <= 1'b0;
      end
      else if (!reached)
         cnt_q <= cnt_q + 18'h00001;
      else
         fault_q <= 1'b1;
   end

   assign fault = fault_q;
endmodule : oc_filter
`default_nettype wire

// file: testbench/overcurrent_filter_select_tb_top.sv
/*
 * self-checking bench for the overcurrent filter-select block: register
 * port, nonvolatile load, per-rail filter lengths, interrupt status.
 * assumes the design's own assertions sit inside the design files.
 */
`timescale 1ns/1ps
`default_nettype none
module overcurrent_filter_select_tb_top;
   localparam int SHORT_C = 8;
   localparam int LONG_C  = 40;
   typedef struct packed {logic [12:0] v; logic [12:0] m;} chk_t;
   logic       clk          = 1'b0;
   logic       srst         = 1'b1;
   logic [7:0] addr         = 8'h00;
   logic [7:0] wdata        = 8'h00;
   logic       wr_en        = 1'b0;
   logic       rd_en        = 1'b0;
   logic [2:0] nvm_defaults = 3'h0;
   logic [8:0] oc_raw       = 9'h000;
   logic [7:0] rdata;
   logic [8:0] oc_fault;
   logic [2:0] long_filter_sel;
   logic       irq;
   logic       rd_d         = 1'b0;
   logic       smp          = 1'b0;
   logic [7:0] rd_q[$];
   chk_t       st_q[$];
   int         fails        = 0;
   int         num_checks   = 0;

   // clock at 100 MHz
   always #5 clk = ~clk;

   overcurrent_filter_select #(.SHORT_CYC(SHORT_C), .LONG_CYC(LONG_C))
      overcurrent_filter_select_i
   (
      .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .nvm_defaults(nvm_defaults),
      .oc_raw(oc_raw), .oc_fault(oc_fault),
      .long_filter_sel(long_filter_sel), .irq(irq)
   );

   // ------------------------------------------------------------
   // monitor: oldest note against what appears
   // ------------------------------------------------------------
   always @(posedge clk)
   begin
      rd_d <= rd_en;
      if (rd_d)
      begin
         num_checks++;
         if (rdata !== rd_q[0])
         begin
            fails++;
            $display("ERROR rdata expected %h seen %h", rd_q[0], rdata);
         end
         void'(rd_q.pop_front());
      end
      if (smp)
      begin
         num_checks++;
         if (({long_filter_sel, irq, oc_fault} & st_q[0].m) !==
             (st_q[0].v & st_q[0].m))
         begin
            fails++;
            $display("ERROR outputs expected %h seen %h mask %h", st_q[0].v,
                     {long_filter_sel, irq, oc_fault}, st_q[0].m);
         end
         void'(st_q.pop_front());
      end
   end

   // ------------------------------------------------------------
   // drivers
   // ------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rd_q.push_back(e);
      @(posedge clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
   endtask : rd

   task automatic st(input logic [12:0] v, input logic [12:0] m);
      st_q.push_back({v, m});
      @(posedge clk);
      smp <= 1'b1;
      @(posedge clk);
      smp <= 1'b0;
   endtask : st

   task automatic pulse(input logic [8:0] b, input int n);
      @(posedge clk);
      oc_raw <= b;
      cyc(n);
      @(posedge clk);
      oc_raw <= 9'h000;
   endtask : pulse

   // short then long selection on one rail, all three detects at once
   task automatic run_rail(input int r);
      logic [8:0] b;
      logic [2:0] s;
      b = 9'h007 << (3 * r);
      for (int lg = 0; lg < 2; lg++)
      begin
         s = 3'(lg << r);
         wr(ocf_pkg::FILTER_SEL_OFS, {5'h00, s});
         pulse(b, SHORT_C - 2);
         pulse(b, SHORT_C - 2);
         st({s, 10'h000}, 13'h1DFF);
         @(posedge clk);
         oc_raw <= b;
         cyc(SHORT_C + 3);
         st({s, 1'b0, (lg == 1) ? 9'h000 : b}, 13'h1DFF);
         cyc(LONG_C);
         st({s, 1'b0, b}, 13'h01FF);
         @(posedge clk);
         oc_raw <= 9'h000;
         cyc(3);
      end
   endtask : run_rail

   task automatic close_out;
      if (fails == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out

   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial
   begin
      logic [7:0] d;
      void'($urandom(32'h9856));
      nvm_defaults = 3'($urandom);
      cyc(3);
      srst <= 1'b0;
      cyc(3);
      rd(ocf_pkg::FILTER_SEL_OFS, {5'h00, nvm_defaults});
      d = 8'($urandom);
      wr(ocf_pkg::FILTER_SEL_OFS, d);
      rd(ocf_pkg::FILTER_SEL_OFS, d & ocf_pkg::SEL_WRITE_MASK);
      rd(8'h10, 8'h00);
      run_rail(0);
      st(13'h0200, 13'h0200);
      rd(ocf_pkg::IRQ_STATUS_OFS, 8'h07);
      wr(ocf_pkg::IRQ_MASK_OFS, 8'hFF);
      rd(ocf_pkg::IRQ_MASK_OFS, 8'hFF);
      st(13'h0000, 13'h0200);
      wr(ocf_pkg::IRQ_STATUS_OFS, 8'h07);
      wr(ocf_pkg::IRQ_MASK_OFS, 8'h00);
      st(13'h0000, 13'h0200);
      rd(ocf_pkg::IRQ_STATUS_OFS, 8'h00);
      run_rail(1);
      run_rail(2);
      rd(ocf_pkg::LOAD_CTRL_OFS, 8'h01);
      st(13'h0200, 13'h0200);
      // software reload of the nonvolatile defaults
      nvm_defaults <= ~nvm_defaults;
      wr(ocf_pkg::LOAD_CTRL_OFS, 8'h01);
      rd(ocf_pkg::FILTER_SEL_OFS, {5'h00, nvm_defaults});
      // reset in mid-run clears status and reloads defaults
      srst         <= 1'b1;
      nvm_defaults <= 3'($urandom);
      cyc(3);
      srst <= 1'b0;
      st({ocf_pkg::SEL_RESET, 10'h000}, 13'h1FFF);
      rd(ocf_pkg::FILTER_SEL_OFS, {5'h00, nvm_defaults});
      rd(ocf_pkg::LOAD_CTRL_OFS, 8'h00);
      rd(ocf_pkg::IRQ_STATUS_OFS, 8'h00);
      cyc(4);
      close_out();
   end

   initial
   begin
      cyc(20000);
      fails++;
      close_out();
   end
endmodule : overcurrent_filter_select_tb_top
`default_nettype wire
